// file: core/csb_top.sv
`timescale 1ns/1ps
`include "csb_map.svh"

module csb_top
  import csb_pkg::*;
#(
  parameter int MS_DIV = `CSB_CLK_HZ / `CSB_MS_PER_S,
  parameter int TONE_DIV = `CSB_CLK_HZ / (2 * `CSB_TONE_HZ)
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic [2:0] STATE_IN,
  input wire logic BUZZER_EN_IN,
  input wire logic BUZZER_DC_IN,
  input wire logic GREEN_INDICATOR_PIN_IN,
  output logic GREEN_INDICATOR_PIN_OUT,
  output logic GREEN_INDICATOR_PIN_OE_N_OUT,
  output logic RED_INDICATOR_BUZZER_PIN_OUT,
  output logic RED_INDICATOR_BUZZER_PIN_OE_N_OUT,
  output logic STANDBY_LAMPS_ON_OUT,
  output logic STRAP_DONE_OUT,
  output logic [2:0] MODE_OUT,
  output logic BUZZER_ACTIVE_OUT
);

  localparam logic [7:0] ALARM_SOUND_CYC = 8'(`CSB_ALARM_SOUND_MS / `CSB_FAST_PERIOD_MS);
  localparam logic [7:0] ALARM_CYC = 8'(`CSB_ALARM_CYCLE_MS / `CSB_FAST_PERIOD_MS);

  ////////////////////////////////////////////////////////////////
  // State decode
  function automatic logic decode_valid(input logic [2:0] code);
    decode_valid = (code == `CSB_CODE_STANDBY) || (code == `CSB_CODE_TRANSFER) ||
      (code == `CSB_CODE_COMPLETE) || (code == `CSB_CODE_FAULT) ||
      (code == `CSB_CODE_FODWARN);
  endfunction

  function automatic csb_mode_t decode_mode(input logic [2:0] code);
    if (code == `CSB_CODE_TRANSFER) begin
      decode_mode = CSB_TRANSFER;
    end else if (code == `CSB_CODE_COMPLETE) begin
      decode_mode = CSB_COMPLETE;
    end else if (code == `CSB_CODE_FAULT) begin
      decode_mode = CSB_FAULT;
    end else if (code == `CSB_CODE_FODWARN) begin
      decode_mode = CSB_FODWARN;
    end else begin
      decode_mode = CSB_STANDBY;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Strap synchroniser and capture
  logic strap_meta;
  logic strap_sync;
  logic [7:0] strap_cnt;
  logic [7:0] next_strap_cnt;
  logic strap_done;
  logic next_strap_done;
  logic stby_on;
  logic next_stby_on;

  always_comb begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_stby_on = stby_on;
    if (!strap_done) begin
      if (strap_cnt == `CSB_STRAP_WAIT) begin
        next_strap_done = 1'b1;
        next_stby_on = ~strap_sync;
      end else begin
        next_strap_cnt = strap_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      strap_cnt <= 8'h00;
      strap_done <= 1'b0;
      stby_on <= 1'b0;
    end else begin
      strap_meta <= GREEN_INDICATOR_PIN_IN;
      strap_sync <= strap_meta;
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      stby_on <= next_stby_on;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Indication mode and timers
  csb_mode_t mode;
  csb_mode_t next_mode;
  logic mode_chg;
  logic ms_tick;
  logic tone_tick;
  logic [15:0] ms_cnt;
  logic [15:0] next_ms_cnt;
  logic [7:0] cyc_cnt;
  logic [7:0] next_cyc_cnt;
  logic [15:0] tone_ms;
  logic [15:0] next_tone_ms;
  logic [15:0] period;
  logic alarm_on;
  logic sounding;

  assign mode_chg = strap_done && decode_valid(STATE_IN) &&
    (decode_mode(STATE_IN) != mode);

  csb_tick #(
    .DIV(MS_DIV)
  ) u_ms_tick (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .clr_in(mode_chg),
    .tick_out(ms_tick)
  );

  csb_tick #(
    .DIV(TONE_DIV)
  ) u_tone_tick (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .clr_in(~sounding),
    .tick_out(tone_tick)
  );

  always_comb begin
    period = (mode == CSB_FODWARN) ? `CSB_FAST_PERIOD_MS : `CSB_SLOW_PERIOD_MS;
    next_mode = mode;
    next_ms_cnt = ms_cnt;
    next_cyc_cnt = cyc_cnt;
    next_tone_ms = tone_ms;
    if (mode_chg) begin
      next_mode = decode_mode(STATE_IN);
      next_ms_cnt = 16'h0000;
      next_cyc_cnt = 8'h00;
      if (decode_mode(STATE_IN) == CSB_TRANSFER) begin
        next_tone_ms = `CSB_XFER_TONE_MS;
      end else begin
        next_tone_ms = 16'h0000;
      end
    end else if (ms_tick) begin
      if (ms_cnt == period - 16'h0001) begin
        next_ms_cnt = 16'h0000;
        if (cyc_cnt == ALARM_CYC - 8'h01) begin
          next_cyc_cnt = 8'h00;
        end else begin
          next_cyc_cnt = cyc_cnt + 8'h01;
        end
      end else begin
        next_ms_cnt = ms_cnt + 16'h0001;
      end
      if (tone_ms != 16'h0000) begin
        next_tone_ms = tone_ms - 16'h0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode <= CSB_STANDBY;
      ms_cnt <= 16'h0000;
      cyc_cnt <= 8'h00;
      tone_ms <= 16'h0000;
    end else begin
      mode <= next_mode;
      ms_cnt <= next_ms_cnt;
      cyc_cnt <= next_cyc_cnt;
      tone_ms <= next_tone_ms;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Lamp and buzzer outputs
  logic green_lit;
  logic red_lit;
  logic sq;
  logic next_sq;
  logic green_out;
  logic green_oe_n;
  logic red_out;
  logic red_oe_n;
  logic next_green_out;
  logic next_green_oe_n;
  logic next_red_out;
  logic next_red_oe_n;

  assign alarm_on = (mode == CSB_FODWARN) && (cyc_cnt < ALARM_SOUND_CYC) &&
    (ms_cnt < `CSB_FAST_ON_MS);
  assign sounding = BUZZER_EN_IN && ((tone_ms != 16'h0000) || alarm_on);

  always_comb begin
    green_lit = 1'b0;
    red_lit = 1'b0;
    case (mode)
      CSB_STANDBY: begin
        green_lit = stby_on;
        red_lit = stby_on;
      end
      CSB_TRANSFER: begin
        green_lit = ms_cnt < `CSB_SLOW_ON_MS;
      end
      CSB_COMPLETE: begin
        green_lit = 1'b1;
      end
      CSB_FAULT: begin
        red_lit = 1'b1;
      end
      CSB_FODWARN: begin
        red_lit = ms_cnt < `CSB_FAST_ON_MS;
      end
      default: begin
        green_lit = 1'b0;
      end
    endcase
    next_sq = sounding ? (sq ^ tone_tick) : 1'b0;
    next_green_out = 1'b0;
    next_green_oe_n = ~(strap_done && green_lit);
    next_red_out = 1'b0;
    next_red_oe_n = ~(strap_done && red_lit);
    if (sounding) begin
      next_red_oe_n = 1'b0;
      next_red_out = BUZZER_DC_IN ? 1'b1 : sq;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sq <= 1'b0;
      green_out <= 1'b0;
      green_oe_n <= 1'b1;
      red_out <= 1'b0;
      red_oe_n <= 1'b1;
    end else begin
      sq <= next_sq;
      green_out <= next_green_out;
      green_oe_n <= next_green_oe_n;
      red_out <= next_red_out;
      red_oe_n <= next_red_oe_n;
    end
  end

  assign GREEN_INDICATOR_PIN_OUT = green_out;
  assign GREEN_INDICATOR_PIN_OE_N_OUT = green_oe_n;
  assign RED_INDICATOR_BUZZER_PIN_OUT = red_out;
  assign RED_INDICATOR_BUZZER_PIN_OE_N_OUT = red_oe_n;
  assign STANDBY_LAMPS_ON_OUT = stby_on;
  assign STRAP_DONE_OUT = strap_done;
  assign MODE_OUT = mode;
  assign BUZZER_ACTIVE_OUT = sounding;

endmodule

// file: shared/csb_map.svh
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// System clock rate and time bases
`define CSB_CLK_HZ 32'h01312D00
`define CSB_MS_PER_S 32'h000003E8
`define CSB_TONE_HZ 32'h000007D0

// Strap sampling delay after reset release, in clock cycles
`define CSB_STRAP_WAIT 8'h10

// Blink timings in milliseconds
`define CSB_SLOW_ON_MS 16'h01F4
`define CSB_SLOW_PERIOD_MS 16'h03E8
`define CSB_FAST_ON_MS 16'h0190
`define CSB_FAST_PERIOD_MS 16'h04B0

// Buzzer timings in milliseconds
`define CSB_XFER_TONE_MS 16'h0190
`define CSB_ALARM_SOUND_MS 16'h7530
`define CSB_ALARM_CYCLE_MS 16'hEA60

// Operating state codes on the state input
`define CSB_CODE_STANDBY 3'h0
`define CSB_CODE_TRANSFER 3'h1
`define CSB_CODE_COMPLETE 3'h2
`define CSB_CODE_FAULT 3'h3
`define CSB_CODE_FODWARN 3'h4

`endif

// file: shared/csb_pkg.sv
package csb_pkg;

  typedef enum logic [2:0] {
    CSB_STANDBY = 3'b000,
    CSB_TRANSFER = 3'b001,
    CSB_COMPLETE = 3'b010,
    CSB_FAULT = 3'b011,
    CSB_FODWARN = 3'b100
  } csb_mode_t;

endpackage

// file: core/csb_tick.sv
`timescale 1ns/1ps

module csb_tick #(
  parameter int DIV = 20000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  output logic tick_out
);

  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic tick;
  logic next_tick;

  localparam logic [23:0] LAST = 24'(DIV - 1);

  ////////////////////////////////////////////////////////////////
  // Prescaler, restarts from zero on clear
  always_comb begin
    next_cnt = cnt + 24'h000001;
    next_tick = 1'b0;
    if (clr_in) begin
      next_cnt = 24'h000000;
    end else if (cnt == LAST) begin
      next_cnt = 24'h000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 24'h000000;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  assign tick_out = tick;

endmodule

// file: sim/csb_top_assertions.sv
`timescale 1ns/1ps
module csb_top_checker
  import csb_pkg::*;
#(
  parameter int MS_DIV = 20,
  parameter int TONE_DIV = 4
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic BUZZER_EN_IN,
  input wire logic BUZZER_DC_IN,
  input wire logic GREEN_INDICATOR_PIN_OE_N_OUT,
  input wire logic RED_INDICATOR_BUZZER_PIN_OUT,
  input wire logic RED_INDICATOR_BUZZER_PIN_OE_N_OUT,
  input wire logic STANDBY_LAMPS_ON_OUT,
  input wire logic STRAP_DONE_OUT,
  input wire logic [2:0] MODE_OUT,
  input wire logic BUZZER_ACTIVE_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////
  // Tone length and steady-pin counters
  int run;
  int hold;
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      run <= 0;
      hold <= 0;
    end else begin
      run <= BUZZER_ACTIVE_OUT ? run + 1 : 0;
      hold <= (BUZZER_ACTIVE_OUT && !BUZZER_DC_IN &&
               !$changed(RED_INDICATOR_BUZZER_PIN_OUT)) ? hold + 1 : 0;
    end
  end
  ////////////////////////////////////////
  red_fault_a: assert property (
    MODE_OUT == CSB_FAULT && $past(MODE_OUT) == CSB_FAULT
    |-> !RED_INDICATOR_BUZZER_PIN_OE_N_OUT) else $error("red dark in fault");
  red_complete_a: assert property (
    MODE_OUT == CSB_COMPLETE && $past(MODE_OUT) == CSB_COMPLETE
    |-> RED_INDICATOR_BUZZER_PIN_OE_N_OUT) else $error("red lit at complete");
  green_fault_a: assert property (
    (MODE_OUT == CSB_FAULT || MODE_OUT == CSB_FODWARN) && $past(MODE_OUT) == MODE_OUT
    |-> GREEN_INDICATOR_PIN_OE_N_OUT) else $error("green lit in fault");
  strap_hold_a: assert property (
    STRAP_DONE_OUT |=> STRAP_DONE_OUT && $stable(STANDBY_LAMPS_ON_OUT))
    else $error("strap option changed");
  standby_show_a: assert property (
    $past(STRAP_DONE_OUT) && MODE_OUT == CSB_STANDBY && $past(MODE_OUT) == CSB_STANDBY
    |-> GREEN_INDICATOR_PIN_OE_N_OUT == !STANDBY_LAMPS_ON_OUT &&
        RED_INDICATOR_BUZZER_PIN_OE_N_OUT == !STANDBY_LAMPS_ON_OUT)
    else $error("standby lamps wrong");
  tone_start_a: assert property (
    MODE_OUT == CSB_TRANSFER && $past(MODE_OUT) != CSB_TRANSFER && BUZZER_EN_IN
    |-> BUZZER_ACTIVE_OUT) else $error("transfer tone late");
  tone_len_a: assert property (
    run <= 400 * MS_DIV + 1) else $error("tone too long");
  tone_rate_a: assert property (
    hold <= TONE_DIV + 2) else $error("tone pin not toggling");
  alarm_red_a: assert property (
    MODE_OUT == CSB_FODWARN && BUZZER_ACTIVE_OUT && $past(BUZZER_ACTIVE_OUT)
    |-> !RED_INDICATOR_BUZZER_PIN_OE_N_OUT) else $error("alarm tone with red dark");
endmodule
bind csb_top csb_top_checker #(.MS_DIV(MS_DIV), .TONE_DIV(TONE_DIV)) chk_u (
  .CORE_CLK_IN(CORE_CLK_IN),
  .RST_IN(RST_IN),
  .BUZZER_EN_IN(BUZZER_EN_IN),
  .BUZZER_DC_IN(BUZZER_DC_IN),
  .GREEN_INDICATOR_PIN_OE_N_OUT(GREEN_INDICATOR_PIN_OE_N_OUT),
  .RED_INDICATOR_BUZZER_PIN_OUT(RED_INDICATOR_BUZZER_PIN_OUT),
  .RED_INDICATOR_BUZZER_PIN_OE_N_OUT(RED_INDICATOR_BUZZER_PIN_OE_N_OUT),
  .STANDBY_LAMPS_ON_OUT(STANDBY_LAMPS_ON_OUT),
  .STRAP_DONE_OUT(STRAP_DONE_OUT),
  .MODE_OUT(MODE_OUT),
  .BUZZER_ACTIVE_OUT(BUZZER_ACTIVE_OUT)
);

// file: sim/csb_lamps_model.sv
`timescale 1ns/1ps
module csb_lamps_model (
  input wire logic pull_up_in,
  input wire logic green_out_in,
  input wire logic green_oe_n_in,
  input wire logic red_oe_n_in,
  output logic green_pad_out,
  output logic green_lit_out,
  output logic red_lit_out
);
  // Strap resistor sets the pad while released
  assign green_pad_out = green_oe_n_in ? pull_up_in : green_out_in;
  // Lamps light while their pin is driven
  assign green_lit_out = !green_oe_n_in;
  assign red_lit_out = !red_oe_n_in;
endmodule

// file: sim/charge_status_led_buzzer_tb_top.sv
`timescale 1ns/1ps
module charge_status_led_buzzer_tb_top;
  logic clk, rst, en, dc, pull, g_out, g_oe_n, r_out, r_oe_n, sb, done, act;
  logic g_pad, g_lit, r_lit, last;
  logic [2:0] state, mode;
  int failures, total_checks, cyc, n, flips;
  csb_top #(.MS_DIV(20), .TONE_DIV(4)) dut_u (.CORE_CLK_IN(clk), .RST_IN(rst),
    .STATE_IN(state), .BUZZER_EN_IN(en), .BUZZER_DC_IN(dc), .GREEN_INDICATOR_PIN_IN(g_pad),
    .GREEN_INDICATOR_PIN_OUT(g_out), .GREEN_INDICATOR_PIN_OE_N_OUT(g_oe_n),
    .RED_INDICATOR_BUZZER_PIN_OUT(r_out), .RED_INDICATOR_BUZZER_PIN_OE_N_OUT(r_oe_n),
    .STANDBY_LAMPS_ON_OUT(sb), .STRAP_DONE_OUT(done), .MODE_OUT(mode),
    .BUZZER_ACTIVE_OUT(act));
  csb_lamps_model lamp_u (.pull_up_in(pull), .green_out_in(g_out), .green_oe_n_in(g_oe_n),
    .red_oe_n_in(r_oe_n), .green_pad_out(g_pad), .green_lit_out(g_lit), .red_lit_out(r_lit));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      conclude();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task go(input logic [2:0] code);
    @(posedge clk);
    state <= code;
  endtask
  task conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task sc_strap(input logic p);
    @(posedge clk);
    pull <= p;
    rst <= 1'b1;
    state <= 3'h0;
    dc <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 40 && done !== 1'b1; i++) wt(1);
    wt(3);
    check(sb, !p, "strap");
    check(g_lit, !p, "green standby");
    check(r_lit, !p, "red standby");
    @(posedge clk);
    pull <= !p;
    wt(50);
    check(sb, !p, "strap held");
  endtask
  task sc_transfer();
    go(3'h1);
    wt(2);
    check(act, 1'b1, "tone on");
    check(g_lit, 1'b1, "green blink on");
    n = 0;
    flips = 0;
    last = r_out;
    while (act === 1'b1 && n < 9000) begin
      wt(1);
      n++;
      if (r_out !== last) flips++;
      last = r_out;
    end
    check(n > 7990 && n < 8003, 1'b1, "tone length");
    check(flips > 1990 && flips < 2010, 1'b1, "tone toggles");
    wt(1);
    check(r_lit, 1'b0, "red off in transfer");
    wt(4000);
    check(g_lit, 1'b0, "green blink off");
    wt(10000);
    check(g_lit, 1'b1, "green blink again");
  endtask
  task sc_quiet();
    go(3'h0);
    en <= 1'b0;
    wt(3);
    check({g_lit, r_lit}, 2'h3, "standby again");
    go(3'h1);
    wt(2);
    check({act, r_lit, r_out}, 3'h0, "no buzzer fitted");
  endtask
  task sc_modes();
    go(3'h2);
    wt(3);
    check(g_lit, 1'b1, "green complete");
    check(r_lit, 1'b0, "red complete");
    check(g_out, 1'b0, "green drive level");
    go(3'h3);
    wt(3);
    check(g_lit, 1'b0, "green fault");
    check(r_lit, 1'b1, "red fault");
    go(3'h5);
    wt(3);
    check(mode, 3'h3, "code ignored");
  endtask
  task sc_fod();
    @(posedge clk);
    state <= 3'h4;
    dc <= 1'b1;
    en <= 1'b1;
    wt(4000);
    check({r_lit, act, r_out}, 3'h7, "alarm on");
    wt(12000);
    check({r_lit, act}, 2'h0, "alarm off");
    wt(12000);
    check({r_lit, act}, 2'h3, "alarm repeat");
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    state = 3'h0;
    en = 1'b1;
    dc = 1'b0;
    pull = 1'b0;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    sc_strap(1'b1);
    sc_strap(1'b0);
    sc_transfer();
    sc_quiet();
    sc_modes();
    sc_fod();
    conclude();
  end
endmodule
